// file: rtl/chg_tlv_pkg.sv
package chg_tlv_pkg;
	localparam int ADDR_W = 12;
	localparam int SID_W = 14;
	localparam int UCD_DEPTH = 512;
	localparam int UCD_PW = 10;
	localparam int SF_MAX = 4;
	localparam int SF_CW = 3;
	// element types of the request
	localparam logic [7:0] T_UCID = 8'h01;
	localparam logic [7:0] T_DSP = 8'h02;
	localparam logic [7:0] T_TECH = 8'h03;
	localparam logic [7:0] T_UCD = 8'h04;
	localparam logic [7:0] T_SAID = 8'h06;
	localparam logic [7:0] T_SFS = 8'h07;
	// subtypes inside type 2 and type 7
	localparam logic [7:0] S_FREQ = 8'h01;
	localparam logic [7:0] S_SYNC = 8'h06;
	localparam logic [7:0] S_SFID = 8'h01;
	localparam logic [7:0] S_SID = 8'h02;
	localparam logic [7:0] L_ONE = 8'h01;
	localparam logic [7:0] L_FOUR = 8'h04;
	localparam logic [7:0] L_EIGHT = 8'h08;
	localparam logic [7:0] SYNC_GO = 8'h01;
	localparam logic [7:0] TECH_TOP = 8'h04;
	localparam logic [2:0] TECH_REINIT = 3'h0;
	localparam logic [2:0] TECH_INIT = 3'h1;
	localparam logic [2:0] TECH_STA = 3'h2;
	localparam logic [2:0] TECH_ANY = 3'h3;
	localparam logic [2:0] TECH_DIRECT = 3'h4;
	// register map (byte addresses)
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_STAT = 12'h004;
	localparam logic [11:0] A_SAID = 12'h008;
	localparam logic [11:0] A_UCDLEN = 12'h00c;
	localparam logic [11:0] A_UCID = 12'h010;
	localparam logic [11:0] A_FREQ = 12'h014;
	localparam logic [3:0] A_FLOW_PAGE = 4'h1;
	localparam logic [13:0] CTRL_RST = 14'h0000;
	localparam int STAT_SYNCW = 3;
	localparam int STAT_SAID = 4;
	localparam int STAT_UCD = 5;
	localparam int STAT_CNT = 8;
	localparam int STAT_BUSY = 12;
	localparam int STAT_UCID = 13;
	localparam int STAT_FREQ = 14;
	typedef enum logic [5:0] {
		P_IDLE = 6'b000001,
		P_TYPE = 6'b000010,
		P_LEN = 6'b000100,
		P_VAL = 6'b001000,
		P_CHSEL = 6'b010000,
		P_DONE = 6'b100000
	} parse_t;
	typedef enum logic [2:0] {
		B_TYPE = 3'b001,
		B_LEN = 3'b010,
		B_VAL = 3'b100
	} sub_t;
endpackage

// file: rtl/channel_change_tlv_decoder.sv
// How it works
// RQ1: decode 2.6: 0 wait, 1 go, rest reserved
// RQ2: no 2.6 element means wait for timing
// RQ3: headend skips wait only with identical timestamps
// RQ4: decode type 3 technique codes zero to four
// RQ5: missing technique means full MAC re-initialisation
// RQ6: present channel choice before technique directive
// RQ7: technique 0 init SID, else primary or substitute
// RQ8: technique 0 ignores all but channel elements
// RQ9: technique 3 allows either maintenance region
// RQ10: technique 4 resumes directly after synchronising
// RQ11: cache type 4 descriptor, apply after sync
// RQ12: headend sends 254-byte fragments except last
// RQ13: join type 4 values in arrival order
// RQ14: headend keeps change count, new channel ID
// RQ15: decode type 6 as two 14-bit identifiers
// RQ16: no type 6 keeps association; keys untouched
// RQ17: one entry per substituted flow, others kept
// RQ18: flow substitution never touches QoS parameters
// RQ19: 7.1 carries flow IDs, required for entry
// RQ20: decode 7.2 as two 14-bit service IDs
// RQ21: no upstream ID element keeps present ID
// RQ22: one-cycle valid strobe after last element
`timescale 1ns/1ps
module channel_change_tlv_decoder
	import chg_tlv_pkg::*;
(
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic MSG_START_I,
	input wire logic MSG_END_I,
	input wire logic BYTE_VALID_I,
	input wire logic [7:0] BYTE_I,
	input wire logic SYNCED_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [chg_tlv_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	output logic [31:0] RDATA_O,
	output logic CHSEL_O,
	output logic UCID_CHG_O,
	output logic [7:0] UCID_O,
	output logic DS_CHG_O,
	output logic [31:0] DS_FREQ_O,
	output logic DONE_O,
	output logic [2:0] TECH_O,
	output logic SYNC_WAIT_O,
	output logic INIT_SID_O,
	output logic [chg_tlv_pkg::SID_W-1:0] RANGE_SID_O,
	output logic INIT_RGN_O,
	output logic STA_RGN_O,
	output logic DIRECT_O,
	output logic SAID_CHG_O,
	output logic [chg_tlv_pkg::SID_W-1:0] SAID_OLD_O,
	output logic [chg_tlv_pkg::SID_W-1:0] SAID_NEW_O,
	output logic UCD_APPLY_O
);
	import chg_tlv_pkg::*;

	function automatic logic [SID_W-1:0] low14(input logic [15:0] f);
		low14 = f[SID_W-1:0];
	endfunction

	parse_t st_ff;
	sub_t sb_ff;
	logic [7:0] typ_ff, len_ff, rem_ff, styp_ff, slen_ff, srem_ff;
	logic [55:0] acc_ff;
	logic [63:0] val_w;
	logic last_w, slast_w, nested_w, vbyte_w, elem_end_w;
	logic ucid_seen_ff, ds_seen_ff, sync_seen_ff, tech_seen_ff, said_seen_ff;
	logic [7:0] ucid_ff, sync_ff;
	logic [31:0] freq_ff;
	logic [2:0] tech_ff, tech_w;
	logic [SID_W-1:0] said_old_ff, said_new_ff, prim_ff;
	logic [UCD_PW-1:0] ucd_ptr_ff;
	logic ucd_seen_ff, ucd_ovf_ff, ucd_ready_ff;
	logic [7:0] ucd_mem [UCD_DEPTH];
	logic [SF_CW-1:0] sf_cnt_ff, pub_cnt_ff;
	logic [1:0] slot_w;
	logic [31:0] sf_old_ff [SF_MAX];
	logic [31:0] sf_new_ff [SF_MAX];
	logic [SID_W-1:0] sid_old_ff [SF_MAX];
	logic [SID_W-1:0] sid_new_ff [SF_MAX];
	logic [SF_MAX-1:0] sf_has_ff, sid_has_ff;
	logic [SID_W-1:0] nxt_range_sid;
	logic sid_sub_w;
	logic [31:0] rd_w;

	assign val_w = {acc_ff, BYTE_I};
	assign last_w = rem_ff == L_ONE;
	assign slast_w = srem_ff == L_ONE;
	assign nested_w = (typ_ff == T_DSP) || (typ_ff == T_SFS);
	assign vbyte_w = BYTE_VALID_I && st_ff == P_VAL;
	assign elem_end_w = (vbyte_w && last_w) ||
		(BYTE_VALID_I && st_ff == P_LEN && BYTE_I == 8'h00);
	assign slot_w = sf_cnt_ff[1:0];
	// missing or reserved technique falls back to a full restart
	assign tech_w = tech_seen_ff ? tech_ff : TECH_REINIT; // [RQ5]

	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
			st_ff <= P_IDLE;
		else if (MSG_START_I)
			st_ff <= P_TYPE;
		else if (MSG_END_I && (st_ff == P_TYPE || st_ff == P_LEN || st_ff == P_VAL))
			st_ff <= P_CHSEL;
		else
		begin
			case (st_ff)
				P_TYPE: if (BYTE_VALID_I) st_ff <= P_LEN;
				P_LEN: if (BYTE_VALID_I) st_ff <= (BYTE_I == 8'h00) ? P_TYPE : P_VAL;
				P_VAL: if (BYTE_VALID_I && last_w) st_ff <= P_TYPE;
				P_CHSEL: st_ff <= P_DONE; // [RQ6]
				P_DONE: st_ff <= P_IDLE;
				P_IDLE: st_ff <= P_IDLE;
				default: st_ff <= P_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			typ_ff <= 8'h00;
			len_ff <= 8'h00;
			rem_ff <= 8'h00;
			acc_ff <= '0;
		end
		else if (BYTE_VALID_I)
		begin
			acc_ff <= val_w[55:0];
			if (st_ff == P_TYPE)
				typ_ff <= BYTE_I;
			if (st_ff == P_LEN)
			begin
				len_ff <= BYTE_I;
				rem_ff <= BYTE_I;
			end
			if (st_ff == P_VAL)
				rem_ff <= rem_ff - 8'h01;
		end
	end

	// sub-element walker for the nested types 2 and 7
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			sb_ff <= B_TYPE;
			styp_ff <= 8'h00;
			slen_ff <= 8'h00;
			srem_ff <= 8'h00;
		end
		else if (st_ff != P_VAL)
			sb_ff <= B_TYPE;
		else if (vbyte_w && nested_w)
		begin
			case (sb_ff)
				B_TYPE:
				begin
					styp_ff <= BYTE_I;
					sb_ff <= B_LEN;
				end
				B_LEN:
				begin
					slen_ff <= BYTE_I;
					srem_ff <= BYTE_I;
					sb_ff <= (BYTE_I == 8'h00) ? B_TYPE : B_VAL;
				end
				B_VAL:
				begin
					srem_ff <= srem_ff - 8'h01;
					if (slast_w)
						sb_ff <= B_TYPE;
				end
				default: sb_ff <= B_TYPE;
			endcase
		end
	end

	// fixed-size elements; a wrong length is ignored, as if the element were absent
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			ucid_seen_ff <= 1'b0;
			ds_seen_ff <= 1'b0;
			sync_seen_ff <= 1'b0;
			tech_seen_ff <= 1'b0;
			said_seen_ff <= 1'b0;
			ucid_ff <= 8'h00;
			sync_ff <= 8'h00;
			freq_ff <= 32'h0;
			tech_ff <= TECH_REINIT;
			said_old_ff <= '0;
			said_new_ff <= '0;
		end
		else if (MSG_START_I)
		begin
			ucid_seen_ff <= 1'b0;
			ds_seen_ff <= 1'b0;
			sync_seen_ff <= 1'b0;
			tech_seen_ff <= 1'b0;
			said_seen_ff <= 1'b0;
		end
		else if (vbyte_w && last_w && !nested_w)
		begin
			if (typ_ff == T_UCID && len_ff == L_ONE)
			begin
				ucid_seen_ff <= 1'b1;
				ucid_ff <= BYTE_I;
			end
			if (typ_ff == T_TECH && len_ff == L_ONE && BYTE_I <= TECH_TOP) // [RQ4]
			begin
				tech_seen_ff <= 1'b1;
				tech_ff <= BYTE_I[2:0];
			end
			if (typ_ff == T_SAID && len_ff == L_FOUR) // [RQ15]
			begin
				said_seen_ff <= 1'b1;
				said_old_ff <= low14(val_w[31:16]);
				said_new_ff <= low14(val_w[15:0]);
			end
		end
		else if (vbyte_w && typ_ff == T_DSP && sb_ff == B_VAL && slast_w)
		begin
			if (styp_ff == S_FREQ && slen_ff == L_FOUR)
			begin
				ds_seen_ff <= 1'b1;
				freq_ff <= val_w[31:0];
			end
			if (styp_ff == S_SYNC && slen_ff == L_ONE) // [RQ1]
			begin
				sync_seen_ff <= 1'b1;
				sync_ff <= BYTE_I;
			end
		end
	end

	// flow table; only identifiers are held, QoS never enters this block [RQ18]
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			sf_cnt_ff <= '0;
			sf_has_ff <= '0;
			sid_has_ff <= '0;
		end
		else if (MSG_START_I)
			sf_cnt_ff <= '0;
		else if (BYTE_VALID_I && st_ff == P_TYPE && BYTE_I == T_SFS && !sf_cnt_ff[2])
		begin
			sf_has_ff[slot_w] <= 1'b0;
			sid_has_ff[slot_w] <= 1'b0;
		end
		else if (elem_end_w && typ_ff == T_SFS && !sf_cnt_ff[2])
		begin
			if (vbyte_w && sb_ff == B_VAL && slast_w && styp_ff == S_SFID && slen_ff == L_EIGHT)
				sf_cnt_ff <= sf_cnt_ff + 3'h1;
			else if (sf_has_ff[slot_w]) // [RQ17] [RQ19]
				sf_cnt_ff <= sf_cnt_ff + 3'h1;
		end
		if (NRST_I && vbyte_w && typ_ff == T_SFS && sb_ff == B_VAL && slast_w && !sf_cnt_ff[2]
			&& !MSG_START_I)
		begin
			if (styp_ff == S_SFID && slen_ff == L_EIGHT) // [RQ19]
			begin
				sf_has_ff[slot_w] <= 1'b1;
				sf_old_ff[slot_w] <= val_w[63:32];
				sf_new_ff[slot_w] <= val_w[31:0];
			end
			if (styp_ff == S_SID && slen_ff == L_FOUR) // [RQ20]
			begin
				sid_has_ff[slot_w] <= 1'b1;
				sid_old_ff[slot_w] <= low14(val_w[31:16]);
				sid_new_ff[slot_w] <= low14(val_w[15:0]);
			end
		end
	end

	// descriptor fragments are appended one after the other in arrival order
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			ucd_ptr_ff <= '0;
			ucd_seen_ff <= 1'b0;
			ucd_ovf_ff <= 1'b0;
		end
		else if (MSG_START_I)
		begin
			ucd_ptr_ff <= '0;
			ucd_seen_ff <= 1'b0;
			ucd_ovf_ff <= 1'b0;
		end
		else if (vbyte_w && typ_ff == T_UCD)
		begin
			ucd_seen_ff <= 1'b1;
			if (ucd_ptr_ff[UCD_PW-1])
				ucd_ovf_ff <= 1'b1;
			else
			begin
				ucd_mem[ucd_ptr_ff[UCD_PW-2:0]] <= BYTE_I; // [RQ11] [RQ13]
				ucd_ptr_ff <= ucd_ptr_ff + 10'h001; // [RQ13]
			end
		end
	end

	always_comb
	begin
		nxt_range_sid = prim_ff;
		sid_sub_w = 1'b0;
		for (int i = 0; i < SF_MAX; i++)
		begin
			if (i < int'(sf_cnt_ff) && sid_has_ff[i] && sid_old_ff[i] == prim_ff)
			begin
				nxt_range_sid = sid_new_ff[i];
				sid_sub_w = 1'b1;
			end
		end
	end

	// channel choice is presented one cycle ahead of the technique
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			CHSEL_O <= 1'b0;
			UCID_CHG_O <= 1'b0;
			UCID_O <= 8'h00;
			DS_CHG_O <= 1'b0;
			DS_FREQ_O <= 32'h0;
		end
		else
		begin
			CHSEL_O <= st_ff == P_CHSEL; // [RQ6]
			if (st_ff == P_CHSEL)
			begin
				UCID_CHG_O <= ucid_seen_ff;
				DS_CHG_O <= ds_seen_ff;
				if (ucid_seen_ff) // [RQ21]
					UCID_O <= ucid_ff;
				if (ds_seen_ff)
					DS_FREQ_O <= freq_ff;
			end
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			DONE_O <= 1'b0;
			TECH_O <= TECH_REINIT;
			SYNC_WAIT_O <= 1'b1;
			INIT_SID_O <= 1'b1;
			RANGE_SID_O <= '0;
			INIT_RGN_O <= 1'b0;
			STA_RGN_O <= 1'b0;
			DIRECT_O <= 1'b0;
			SAID_CHG_O <= 1'b0;
			SAID_OLD_O <= '0;
			SAID_NEW_O <= '0;
			pub_cnt_ff <= '0;
		end
		else
		begin
			DONE_O <= st_ff == P_DONE; // [RQ22]
			if (st_ff == P_DONE)
			begin
				TECH_O <= tech_w; // [RQ4]
				INIT_SID_O <= tech_w == TECH_REINIT; // [RQ7]
				RANGE_SID_O <= (tech_w == TECH_REINIT) ? '0 : nxt_range_sid; // [RQ7]
				SYNC_WAIT_O <= tech_w == TECH_REINIT || !sync_seen_ff
					|| sync_ff != SYNC_GO; // [RQ1] [RQ2] [RQ8]
				INIT_RGN_O <= tech_w == TECH_INIT || tech_w == TECH_ANY; // [RQ9]
				STA_RGN_O <= tech_w == TECH_STA || tech_w == TECH_ANY; // [RQ9]
				DIRECT_O <= tech_w == TECH_DIRECT; // [RQ10]
				// a new association reuses the same keys, so no key action here
				SAID_CHG_O <= said_seen_ff && tech_w != TECH_REINIT; // [RQ8] [RQ16]
				SAID_OLD_O <= said_old_ff;
				SAID_NEW_O <= said_new_ff;
				pub_cnt_ff <= (tech_w == TECH_REINIT) ? '0 : sf_cnt_ff; // [RQ8]
			end
		end
	end

	// descriptor is held back until the new channel reports sync
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			ucd_ready_ff <= 1'b0;
			UCD_APPLY_O <= 1'b0;
		end
		else
		begin
			UCD_APPLY_O <= ucd_ready_ff && SYNCED_I && !MSG_START_I; // [RQ11]
			if (st_ff == P_DONE)
				ucd_ready_ff <= ucd_seen_ff && !ucd_ovf_ff && tech_w != TECH_REINIT;
			else if (MSG_START_I || SYNCED_I)
				ucd_ready_ff <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
			prim_ff <= CTRL_RST;
		else if (WR_I && ADDR_I == A_CTRL)
			prim_ff <= WDATA_I[SID_W-1:0];
	end

	always_comb
	begin
		rd_w = 32'h0;
		if (ADDR_I[11] && ADDR_I[1:0] == 2'b00)
			rd_w = {24'h0, ucd_mem[ADDR_I[10:2]]};
		else if (ADDR_I[11:8] == A_FLOW_PAGE && ADDR_I[7:6] == 2'b00 && ADDR_I[1:0] == 2'b00)
		begin
			case (ADDR_I[3:2])
				2'h0: rd_w = sf_old_ff[ADDR_I[5:4]];
				2'h1: rd_w = sf_new_ff[ADDR_I[5:4]];
				2'h2: rd_w = {2'h0, sid_old_ff[ADDR_I[5:4]], 2'h0, sid_new_ff[ADDR_I[5:4]]};
				default: rd_w = {30'h0, sid_has_ff[ADDR_I[5:4]], sf_has_ff[ADDR_I[5:4]]};
			endcase
		end
		else
		begin
			case (ADDR_I)
				A_CTRL: rd_w = {18'h0, prim_ff};
				A_STAT:
				begin
					rd_w[2:0] = TECH_O;
					rd_w[STAT_SYNCW] = SYNC_WAIT_O;
					rd_w[STAT_SAID] = SAID_CHG_O;
					rd_w[STAT_UCD] = ucd_ready_ff;
					rd_w[STAT_CNT +: SF_CW] = pub_cnt_ff;
					rd_w[STAT_BUSY] = st_ff != P_IDLE;
					rd_w[STAT_UCID] = UCID_CHG_O;
					rd_w[STAT_FREQ] = DS_CHG_O;
				end
				A_SAID: rd_w = {2'h0, SAID_NEW_O, 2'h0, SAID_OLD_O};
				A_UCDLEN: rd_w = {22'h0, ucd_ptr_ff};
				A_UCID: rd_w = {24'h0, UCID_O};
				A_FREQ: rd_w = DS_FREQ_O;
				default: rd_w = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
			RDATA_O <= 32'h0;
		else
			RDATA_O <= RD_I ? rd_w : 32'h0;
	end

	done_after_chsel_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ6]
		DONE_O |-> $past(CHSEL_O))
		else $error("done strobe without channel select before it");
	done_single_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ22]
		CHSEL_O |=> DONE_O ##1 !DONE_O)
		else $error("done strobe not a single cycle after channel select");
	absent_sync_wait_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ2]
		DONE_O && !sync_seen_ff |-> SYNC_WAIT_O)
		else $error("no sync element but wait not requested");
	sync_go_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ1]
		DONE_O && sync_seen_ff && TECH_O != TECH_REINIT |-> SYNC_WAIT_O == (sync_ff != SYNC_GO))
		else $error("sync element value decoded wrongly");
	absent_tech_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ5]
		DONE_O && !tech_seen_ff |-> TECH_O == TECH_REINIT && INIT_SID_O)
		else $error("missing technique did not force reinit");
	tech0_mask_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ8]
		DONE_O && TECH_O == TECH_REINIT |-> !SAID_CHG_O && pub_cnt_ff == '0 ##1 !ucd_ready_ff)
		else $error("technique 0 acted on extra elements");
	range_prim_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ7]
		DONE_O && TECH_O != TECH_REINIT && !$past(sid_sub_w) |-> RANGE_SID_O == $past(prim_ff))
		else $error("ranging SID is not the primary SID");
	regions_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ9]
		DONE_O && TECH_O == TECH_ANY |-> INIT_RGN_O && STA_RGN_O && !DIRECT_O)
		else $error("technique 3 must allow both regions");
	ucid_keep_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ21]
		CHSEL_O && !UCID_CHG_O |-> $stable(UCID_O))
		else $error("upstream channel ID changed without element");
	ucd_sync_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ11]
		UCD_APPLY_O |-> $past(SYNCED_I) && $past(ucd_ready_ff))
		else $error("descriptor applied before sync");
	ucd_append_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ13]
		vbyte_w && typ_ff == T_UCD && !ucd_ptr_ff[UCD_PW-1] && !MSG_START_I
		|=> ucd_ptr_ff == $past(ucd_ptr_ff) + 10'h001)
		else $error("descriptor byte not appended");

	direct_c: cover property (@(posedge CLK_I) DONE_O && DIRECT_O);
	reinit_c: cover property (@(posedge CLK_I) DONE_O && TECH_O == TECH_REINIT);
	two_flows_c: cover property (@(posedge CLK_I) DONE_O && pub_cnt_ff == 3'h2);
	ucd_apply_c: cover property (@(posedge CLK_I) UCD_APPLY_O);
endmodule

// file: sim/headend_model.sv
`timescale 1ns/1ps
module headend_model (
	input wire logic clk_i,
	output logic msg_start_o,
	output logic msg_end_o,
	output logic byte_valid_o,
	output logic [7:0] byte_o
);
	logic [7:0] q[$];

	initial
	begin
		msg_start_o = 1'b0;
		msg_end_o = 1'b0;
		byte_valid_o = 1'b0;
		byte_o = 8'h00;
	end

	task automatic put(input logic [7:0] b);
		q.push_back(b);
	endtask

	// proceed-at-once is only offered when both channels share one timestamp clock
	task automatic put_sync(input logic [7:0] v);
		put(8'h02);
		put(8'h03);
		put(8'h06);
		put(8'h01);
		put(v);
	endtask

	// full fragments first, remainder last; caller also sends a fresh upstream id
	task automatic put_ucd(input int n);
		int k;
		for (k = 0; k < n; k++)
		begin
			if (k % 254 == 0)
			begin
				put(8'h04);
				put(8'((n - k > 254) ? 254 : n - k));
			end
			put(8'(k) ^ 8'h5a);
		end
	endtask

	// idle bytes show a changing pattern so a stale value never looks valid
	task automatic send(input int gap);
		int g;
		@(posedge clk_i);
		msg_start_o <= 1'b1;
		@(posedge clk_i);
		msg_start_o <= 1'b0;
		while (q.size() > 0)
		begin
			byte_valid_o <= 1'b1;
			byte_o <= q.pop_front();
			@(posedge clk_i);
			for (g = 0; g < gap; g++)
			begin
				byte_valid_o <= 1'b0;
				byte_o <= ~byte_o;
				@(posedge clk_i);
			end
		end
		byte_valid_o <= 1'b0;
		byte_o <= ~byte_o;
		msg_end_o <= 1'b1;
		@(posedge clk_i);
		msg_end_o <= 1'b0;
	endtask
endmodule

// file: sim/test_channel_change_tlv_decoder.sv
`timescale 1ns/1ps
module test_channel_change_tlv_decoder;
	import chg_tlv_pkg::*;
	typedef struct {logic [8:0] tech; logic [8:0] sync; logic [2:0] et; logic [4:0] ef;} row_t;
	logic clk, nrst, ms, me, bv, synced, wr, rd, chsel, done, ucid_chg, ds_chg;
	logic sync_wait, init_sid, init_rgn, sta_rgn, direct, said_chg, ucd_apply;
	logic [7:0] bt, ucid;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, ds_freq, d;
	logic [2:0] tech;
	logic [13:0] range_sid, said_old, said_new;
	int fails, checks_done, applies;
	// flags are {wait, init sid, initial rgn, station rgn, direct}; bit 8 marks present
	row_t rows[9] = '{
		'{9'h000, 9'h000, 3'h0, 5'b11000}, '{9'h100, 9'h101, 3'h0, 5'b11000},
		'{9'h101, 9'h101, 3'h1, 5'b00100}, '{9'h102, 9'h100, 3'h2, 5'b10010},
		'{9'h103, 9'h102, 3'h3, 5'b10110}, '{9'h104, 9'h101, 3'h4, 5'b00001},
		'{9'h105, 9'h101, 3'h0, 5'b11000}, '{9'h104, 9'h000, 3'h4, 5'b10001},
		'{9'h104, 9'h1ff, 3'h4, 5'b10001}};

	channel_change_tlv_decoder DUT (.CLK_I(clk), .NRST_I(nrst), .MSG_START_I(ms),
		.MSG_END_I(me), .BYTE_VALID_I(bv), .BYTE_I(bt), .SYNCED_I(synced), .WR_I(wr),
		.RD_I(rd), .ADDR_I(addr), .WDATA_I(wdata), .RDATA_O(rdata), .CHSEL_O(chsel),
		.UCID_CHG_O(ucid_chg), .UCID_O(ucid), .DS_CHG_O(ds_chg), .DS_FREQ_O(ds_freq),
		.DONE_O(done), .TECH_O(tech), .SYNC_WAIT_O(sync_wait), .INIT_SID_O(init_sid),
		.RANGE_SID_O(range_sid), .INIT_RGN_O(init_rgn), .STA_RGN_O(sta_rgn),
		.DIRECT_O(direct), .SAID_CHG_O(said_chg), .SAID_OLD_O(said_old),
		.SAID_NEW_O(said_new), .UCD_APPLY_O(ucd_apply));
	headend_model HE (.clk_i(clk), .msg_start_o(ms), .msg_end_o(me), .byte_valid_o(bv),
		.byte_o(bt));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
		if (ucd_apply === 1'b1)
			applies++;

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic pb(input logic [7:0] b[$]);
		foreach (b[i])
			HE.put(b[i]);
	endtask

	task automatic wreg(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [11:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic req(input int gap);
		int n;
		logic ch;
		ch = 1'b0;
		HE.send(gap);
		for (n = 0; n < 20 && done !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
			if (done !== 1'b1)
				ch = (chsel === 1'b1);
		end
		chk("done", 32'(done), 32'h1);
		chk("chsel_first", 32'(ch), 32'h1);
		@(posedge clk);
		#1;
		chk("done_pulse", 32'(done), 32'h0);
	endtask

	task automatic do_reset();
		nrst <= 1'b0;
		repeat (16) @(posedge clk);
		#1;
		chk("rst_out", 32'({sync_wait, init_sid, tech, direct, ucid}), 32'h3000);
		@(posedge clk);
		nrst <= 1'b1;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		report_and_stop();
	end

	initial
	begin
		{nrst, synced, wr, rd, addr, wdata} = '0;
		do_reset();
		wreg(A_CTRL, 32'h0000_0123);
		rreg(A_CTRL);
		chk("ctrl", d, 32'h123);
		rreg(12'h3f0);
		chk("unmapped", d, 32'h0);
		foreach (rows[i])
		begin
			if (rows[i].sync[8])
				HE.put_sync(rows[i].sync[7:0]);
			if (rows[i].tech[8])
				pb('{8'h03, 8'h01, rows[i].tech[7:0]});
			req(i % 2);
			chk("tech", 32'(tech), 32'(rows[i].et));
			chk("flags", 32'({sync_wait, init_sid, init_rgn, sta_rgn, direct}),
				32'(rows[i].ef));
			chk("rsid", 32'(range_sid), rows[i].ef[3] ? 32'h0 : 32'h123);
		end
		// full request: channels, technique 1, association and two substituted flows
		pb('{8'h01, 8'h01, 8'h2a, 8'h02, 8'h06, 8'h01, 8'h04, 8'h05, 8'hf5, 8'he1, 8'h00});
		pb('{8'h03, 8'h01, 8'h01, 8'h06, 8'h04, 8'hc0, 8'h11, 8'h80, 8'h22});
		pb('{8'h07, 8'h10, 8'h01, 8'h08, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00,
			8'h09, 8'h02, 8'h04, 8'hc1, 8'h23, 8'h04, 8'h56});
		pb('{8'h07, 8'h0a, 8'h01, 8'h08, 8'h00, 8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h0a});
		req(0);
		chk("ucid", 32'({ucid_chg, ucid}), 32'h12a);
		chk("freq", {31'(ds_chg), ds_freq[0]}, 32'h2);
		chk("freq_val", ds_freq, 32'h05f5e100);
		chk("said", 32'({said_chg, said_old, said_new}), 32'h1004_4022);
		chk("rsid_sub", 32'(range_sid), 32'h456);
		rreg(A_STAT);
		chk("flow_cnt", 32'(d[10:8]), 32'h2);
		rreg(12'h104);
		chk("new_sfid", d, 32'h9);
		rreg(12'h114);
		chk("new_sfid2", d, 32'ha);
		rreg(12'h108);
		chk("flow_sid", d, 32'h0123_0456);
		// flow lacking its identifier pair, no channel or association elements
		// the orphan service id matches the primary, so counting it would show on ranging
		pb('{8'h03, 8'h01, 8'h02, 8'h07, 8'h06, 8'h02, 8'h04, 8'h01, 8'h23, 8'h00, 8'h02});
		req(1);
		chk("ucid_kept", 32'({ucid_chg, ucid}), 32'h02a);
		chk("said_kept", 32'(said_chg), 32'h0);
		chk("rsid_prim", 32'(range_sid), 32'h123);
		rreg(A_STAT);
		chk("flow_none", 32'(d[10:8]), 32'h0);
		// full reinit ignores association and flows but not the channel id
		pb('{8'h01, 8'h01, 8'h07, 8'h03, 8'h01, 8'h00, 8'h06, 8'h04, 8'h00, 8'h33, 8'h00, 8'h44});
		pb('{8'h07, 8'h0a, 8'h01, 8'h08, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h09});
		req(0);
		chk("r0_out", 32'({ucid, said_chg, range_sid}), 32'({8'h07, 1'b0, 14'h0}));
		rreg(A_STAT);
		chk("r0_flows", 32'(d[10:8]), 32'h0);
		// fragmented descriptor, held until the new channel is synchronised
		HE.put_ucd(300);
		pb('{8'h03, 8'h01, 8'h04, 8'h01, 8'h01, 8'h09});
		applies = 0;
		req(0);
		rreg(A_UCDLEN);
		chk("ucd_len", d, 32'd300);
		rreg(12'hbf8);
		chk("ucd_join", 32'(d[7:0]), 32'(8'(254) ^ 8'h5a));
		chk("no_early", 32'(applies), 32'h0);
		@(posedge clk);
		synced <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk("apply", 32'(applies), 32'h1);
		@(posedge clk);
		do_reset();
		rreg(A_CTRL);
		chk("ctrl_rst", d, 32'h0);
		report_and_stop();
	end
endmodule
